/* File: verilog/tick_unit_cfg.svh */
/*
  Address map, field positions, reset values and sizes of the periodic
  tick unit. Assumes it is included by bare name from the verilog folder.
*/
`ifndef TICK_UNIT_CFG_SVH
`define TICK_UNIT_CFG_SVH

// bus widths
`define TICK_ADDR_W 8
`define TICK_DATA_W 8

// register addresses
`define TICK_CTRL_ADDR 8'h00
`define TICK_COUNT_LO_ADDR 8'h01
`define TICK_COUNT_HI_ADDR 8'h02
`define TICK_UNMAPPED_DATA 8'h00

// control register fields
`define TICK_FLAG_BIT 7
`define TICK_RATE_MSB 6
`define TICK_RATE_LSB 4
`define TICK_ACK_BIT 3
`define TICK_IRQ_ALLOW_BIT 2
`define TICK_ON_BIT 1
`define TICK_RATE_RESET 3'h0

// divider chain
`define TICK_STAGES 15
`define TICK_RATE_W 3
`define TICK_TAP_W 4
`define TICK_OSC_HZ 32768

// tap bit whose rising edge marks one event; divide ratio is 2**(tap+1)
`define TICK_TAP_DIV32768 4'he
`define TICK_TAP_DIV8192 4'hc
`define TICK_TAP_DIV2048 4'ha
`define TICK_TAP_DIV128 4'h6
`define TICK_TAP_DIV64 4'h5
`define TICK_TAP_DIV32 4'h4
`define TICK_TAP_DIV16 4'h3
`define TICK_TAP_DIV8 4'h2

`endif

/* File: verilog/tick_pkg.sv */
/*
  Types shared by the periodic tick unit, its checker and its bench.
  Assumes tick_unit_cfg.svh is on the include path.
*/
`default_nettype none
`include "tick_unit_cfg.svh"

package tick_pkg;

  typedef struct packed {
    logic [`TICK_ADDR_W-1:0] addr;
    logic [`TICK_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;

  typedef struct packed {
    logic wait_mode;
    logic stop_mode;
    logic osc_run_in_stop;
  } power_s;

  typedef struct packed {
    logic [`TICK_RATE_W-1:0] tick_rate_select;
    logic tick_irq_allow;
    logic tick_chain_on;
  } ctrl_s;

  typedef enum logic [3:0] {
    PWR_RUN = 4'h1,
    PWR_WAIT = 4'h2,
    PWR_STOP_OSC = 4'h4,
    PWR_STOP_DARK = 4'h8
  } power_state_e;

endpackage : tick_pkg

`default_nettype wire

/* File: verilog/tick_divider.sv */
/*
  Ripple divider chain of the tick unit with a selectable event tap.
  Assumes i_advance is a one-cycle pulse per tick source clock edge and
  that the reset it receives is already synchronised.
*/
`default_nettype none
`include "tick_unit_cfg.svh"

module tick_divider #(
  parameter int STAGES = `TICK_STAGES,
  parameter int TAP_W = `TICK_TAP_W
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_chain_on,
  input wire logic i_advance,
  input wire logic [TAP_W-1:0] i_tap,
  output logic [STAGES-1:0] o_count,
  output logic o_event
);

  logic [STAGES-1:0] count;
  logic [STAGES-1:0] next_count;
  logic [STAGES:0] carry;

  ////////////////////////////////////////////////////////////////////////
  assign carry[0] = i_advance & i_chain_on;

  // [RL1] fifteen toggle stages
  for (genvar g = 0; g < STAGES; g++) begin : g_stage
    assign carry[g+1] = carry[g] & count[g];
    always_comb begin
      // [RL3] held at zero while off
      if (!i_chain_on) begin
        next_count[g] = 1'b0;
      end else begin
        next_count[g] = count[g] ^ carry[g];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // [RL7] tap bit rising: first at half period, then every period
  assign o_event = carry[i_tap] & ~count[i_tap];
  assign o_count = count;

endmodule : tick_divider

`default_nettype wire

/* File: verilog/periodic_tick_unit.sv */
/*
  Periodic tick unit: a divider chain advanced by the tick source clock
  raises a pending flag at a selectable rate and may request an interrupt.
  Assumes all inputs are synchronous to i_clk, the bus master keeps the
  strobe protocol, and the power mode inputs come from the system core.
*/
`default_nettype none
`include "tick_unit_cfg.svh"

// Notes on behaviour
// [RL1] fifteen divider stages, eight selectable taps
// [RL2] chain advances on tick source clock edges
// [RL3] chain held at zero while disabled
// [RL4] counting starts from zero when enabled
// [RL5] tap overflow sets the read-only pending flag
// [RL6] rate field selects divide 32768 down to 8
// [RL7] first event at half period, then full
// [RL8] flag and allow bit raise interrupt request
// [RL9] clear bit is write-one, always reads zero
// [RL10] software acknowledges each interrupt by clear write
// [RL11] software changes rate only while disabled
// [RL12] reset clears the interrupt allow bit
// [RL13] reset clears the chain enable bit
// [RL14] wait mode keeps counting, register access blocked
// [RL15] stop with oscillator keeps the unit running
// [RL16] stop without oscillator: unit inactive, no access
// [RL17] software turns unit off before low power
// [RL18] interrupt request is a level, both bits
module periodic_tick_unit #(
  parameter int STAGES = `TICK_STAGES,
  parameter int OSC_HZ = `TICK_OSC_HZ
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire tick_pkg::bus_req_s i_bus,
  input wire logic i_tick_source_clock,
  input wire tick_pkg::power_s i_power,
  output logic [`TICK_DATA_W-1:0] o_rdata,
  output logic o_irq,
  output logic o_chain_active,
  output logic o_tick_event
);

  import tick_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // decoding helpers

  function automatic logic addr_hit(
    input logic [`TICK_ADDR_W-1:0] addr,
    input logic [`TICK_ADDR_W-1:0] target
  );
    addr_hit = (addr == target);
  endfunction : addr_hit

  // [RL6] rate code to tap bit
  function automatic logic [`TICK_TAP_W-1:0] tap_of(
    input logic [`TICK_RATE_W-1:0] rate
  );
    case (rate)
      3'h0: tap_of = `TICK_TAP_DIV32768;
      3'h1: tap_of = `TICK_TAP_DIV8192;
      3'h2: tap_of = `TICK_TAP_DIV2048;
      3'h3: tap_of = `TICK_TAP_DIV128;
      3'h4: tap_of = `TICK_TAP_DIV64;
      3'h5: tap_of = `TICK_TAP_DIV32;
      3'h6: tap_of = `TICK_TAP_DIV16;
      3'h7: tap_of = `TICK_TAP_DIV8;
      default: tap_of = `TICK_TAP_DIV32768;
    endcase
  endfunction : tap_of

  ////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_meta_n;
  logic rst_n;

  // async assert, release through two flops
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power mode tracking

  power_state_e pwr;
  power_state_e next_pwr;

  always_comb begin
    case (pwr)
      PWR_RUN,
      PWR_WAIT,
      PWR_STOP_OSC,
      PWR_STOP_DARK: begin
        if (i_power.stop_mode && i_power.osc_run_in_stop) begin
          next_pwr = PWR_STOP_OSC;
        end else if (i_power.stop_mode) begin
          next_pwr = PWR_STOP_DARK;
        end else if (i_power.wait_mode) begin
          next_pwr = PWR_WAIT;
        end else begin
          next_pwr = PWR_RUN;
        end
      end
      default: begin
        next_pwr = PWR_RUN;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr <= PWR_RUN;
    end else begin
      pwr <= next_pwr;
    end
  end

  logic bus_open;
  logic unit_alive;

  // [RL14] access only in run mode
  assign bus_open = (pwr == PWR_RUN);
  // [RL15] only dark stop halts the chain
  assign unit_alive = (pwr != PWR_STOP_DARK);

  ////////////////////////////////////////////////////////////////////////
  // tick source edge detection

  logic src_prev;
  logic next_src_prev;
  logic advance;

  always_comb begin
    next_src_prev = i_tick_source_clock;
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      src_prev <= 1'b0;
    end else begin
      src_prev <= next_src_prev;
    end
  end

  // [RL2] one step per source clock rising edge
  // [RL16] no steps while stopped without oscillator
  assign advance = i_tick_source_clock & ~src_prev & unit_alive;

  ////////////////////////////////////////////////////////////////////////
  // control register and pending flag

  ctrl_s ctrl;
  ctrl_s next_ctrl;
  logic flag;
  logic next_flag;
  logic ctrl_wr;
  logic ack_wr;
  logic tick_event;
  logic [STAGES-1:0] count;

  assign ctrl_wr = i_bus.wr & bus_open & addr_hit(i_bus.addr, `TICK_CTRL_ADDR);
  // [RL9] only a written one clears
  assign ack_wr = ctrl_wr & i_bus.wdata[`TICK_ACK_BIT];

  always_comb begin
    next_ctrl = ctrl;
    if (ctrl_wr) begin
      next_ctrl.tick_rate_select =
        i_bus.wdata[`TICK_RATE_MSB:`TICK_RATE_LSB];
      next_ctrl.tick_irq_allow = i_bus.wdata[`TICK_IRQ_ALLOW_BIT];
      next_ctrl.tick_chain_on = i_bus.wdata[`TICK_ON_BIT];
    end
  end

  always_comb begin
    next_flag = flag;
    // [RL5] overflow sets; a same-cycle clear loses
    if (tick_event) begin
      next_flag = 1'b1;
    end else if (ack_wr) begin
      next_flag = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      // [RL12] [RL13] allow and enable cleared
      ctrl.tick_rate_select <= `TICK_RATE_RESET;
      ctrl.tick_irq_allow <= 1'b0;
      ctrl.tick_chain_on <= 1'b0;
      flag <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      flag <= next_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // divider chain

  // [RL3] [RL4] chain cleared when off, counts up from zero when on
  tick_divider #(
    .STAGES(STAGES),
    .TAP_W(`TICK_TAP_W)
  ) u_divider (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_chain_on(ctrl.tick_chain_on),
    .i_advance(advance),
    .i_tap(tap_of(ctrl.tick_rate_select)),
    .o_count(count),
    .o_event(tick_event)
  );

  ////////////////////////////////////////////////////////////////////////
  // register reads

  logic [`TICK_DATA_W-1:0] rdata;
  logic [`TICK_DATA_W-1:0] next_rdata;
  logic [`TICK_DATA_W-1:0] hi_hold;
  logic [`TICK_DATA_W-1:0] next_hi_hold;
  logic [`TICK_DATA_W-1:0] ctrl_view;
  logic [`TICK_DATA_W-1:0] lo_view;
  logic [`TICK_DATA_W-1:0] hi_view;
  logic rd_ok;

  assign rd_ok = i_bus.rd & bus_open;

  always_comb begin
    ctrl_view = '0;
    ctrl_view[`TICK_FLAG_BIT] = flag;
    ctrl_view[`TICK_RATE_MSB:`TICK_RATE_LSB] = ctrl.tick_rate_select;
    // [RL9] clear bit reads as zero
    ctrl_view[`TICK_ACK_BIT] = 1'b0;
    ctrl_view[`TICK_IRQ_ALLOW_BIT] = ctrl.tick_irq_allow;
    ctrl_view[`TICK_ON_BIT] = ctrl.tick_chain_on;
  end

  always_comb begin
    lo_view = count[`TICK_DATA_W-1:0];
    hi_view = '0;
    hi_view[STAGES-`TICK_DATA_W-1:0] = count[STAGES-1:`TICK_DATA_W];
  end

  // a low-byte read freezes the high byte so both halves match
  always_comb begin
    next_hi_hold = hi_hold;
    if (rd_ok && addr_hit(i_bus.addr, `TICK_COUNT_LO_ADDR)) begin
      next_hi_hold = hi_view;
    end
  end

  always_comb begin
    next_rdata = `TICK_UNMAPPED_DATA;
    if (rd_ok) begin
      if (addr_hit(i_bus.addr, `TICK_CTRL_ADDR)) begin
        next_rdata = ctrl_view;
      end else if (addr_hit(i_bus.addr, `TICK_COUNT_LO_ADDR)) begin
        next_rdata = lo_view;
      end else if (addr_hit(i_bus.addr, `TICK_COUNT_HI_ADDR)) begin
        next_rdata = hi_hold;
      end else begin
        next_rdata = `TICK_UNMAPPED_DATA;
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
      hi_hold <= '0;
    end else begin
      rdata <= next_rdata;
      hi_hold <= next_hi_hold;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  logic irq;
  logic next_irq;

  // [RL8] [RL18] level from next flag and allow
  // built from next values so the request drops with the clear write
  always_comb begin
    next_irq = next_flag & next_ctrl.tick_irq_allow;
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  logic active;
  logic next_active;

  // enabled and not halted by a dark stop
  always_comb begin
    next_active = next_ctrl.tick_chain_on & unit_alive;
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      active <= 1'b0;
    end else begin
      active <= next_active;
    end
  end

  logic evt;
  logic next_evt;

  // pulse registered on the same edge that sets the flag
  always_comb begin
    next_evt = tick_event;
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      evt <= 1'b0;
    end else begin
      evt <= next_evt;
    end
  end

  assign o_rdata = rdata;
  assign o_irq = irq;
  assign o_chain_active = active;
  assign o_tick_event = evt;

endmodule : periodic_tick_unit

`default_nettype wire

/* File: bench/periodic_tick_unit_checker.sv */
/*
  Port-level assertions for the periodic tick unit.
  Assumes the unit's ports as declared and the bus strobe protocol.
*/
`default_nettype none
`include "tick_unit_cfg.svh"

module periodic_tick_unit_checker
  import tick_pkg::*;
#(
  parameter int STAGES = `TICK_STAGES,
  parameter int OSC_HZ = `TICK_OSC_HZ
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire tick_pkg::bus_req_s i_bus,
  input wire logic i_tick_source_clock,
  input wire tick_pkg::power_s i_power,
  input wire logic [`TICK_DATA_W-1:0] o_rdata,
  input wire logic o_irq,
  input wire logic o_chain_active,
  input wire logic o_tick_event
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  //////////////////////////////////////////////////////////////////////////
  rdata_idle_a:
    assert property (!$past(i_bus.rd) |-> o_rdata == 8'h00)
    else $error("read data not idle");
  event_pulse_a:
    assert property (o_tick_event |=> !o_tick_event)
    else $error("event pulse too long");
  irq_hold_a:
    assert property (o_irq && !(i_bus.wr && i_bus.addr == `TICK_CTRL_ADDR)
      |=> o_irq) else $error("irq dropped without write");
  irq_rise_a:
    assert property ($rose(o_irq) && !$past(i_bus.wr) |-> o_tick_event)
    else $error("irq rose without event");
  ctrl_zero_a:
    assert property ($past(i_bus.rd && i_bus.addr == `TICK_CTRL_ADDR)
      |-> !o_rdata[`TICK_ACK_BIT] && !o_rdata[0])
    else $error("clear bit read nonzero");
  count_high_a:
    assert property ($past(i_bus.rd && i_bus.addr == `TICK_COUNT_HI_ADDR)
      |-> !o_rdata[7]) else $error("count wider than chain");
  irq_read_a:
    assert property ($past(i_bus.rd && i_bus.addr == `TICK_CTRL_ADDR &&
      o_irq) && !$past(i_power.wait_mode || i_power.stop_mode, 2)
      |-> o_rdata[7] && o_rdata[2]) else $error("irq without flag");
  blocked_read_a:
    assert property ($past(i_bus.rd) &&
      $past(i_power.wait_mode || i_power.stop_mode, 2)
      |-> o_rdata == 8'h00) else $error("read in low power");
endmodule : periodic_tick_unit_checker

bind periodic_tick_unit periodic_tick_unit_checker #(
  .STAGES(STAGES), .OSC_HZ(OSC_HZ)) i_chk (.i_clk(i_clk),
  .i_reset_n(i_reset_n), .i_bus(i_bus),
  .i_tick_source_clock(i_tick_source_clock), .i_power(i_power),
  .o_rdata(o_rdata), .o_irq(o_irq), .o_chain_active(o_chain_active),
  .o_tick_event(o_tick_event));

`default_nettype wire

/* File: bench/tb_periodic_tick_unit.sv */
/*
  Self-checking bench of the periodic tick unit.
  Assumes the unit as declared; the source clock is run fast (period of
  four system cycles) so that the slow rates fit in the run.
*/
`default_nettype none
`include "tick_unit_cfg.svh"

module tb_periodic_tick_unit;
  timeunit 1ns;
  timeprecision 1ns;
  import tick_pkg::*;
  logic i_clk = 0, i_reset_n = 0, src = 0, src_d = 0, src_run = 1;
  logic on_m = 0, al;
  bus_req_s bus = '0;
  power_s pwr = '0, pwr_q = '0;
  logic [7:0] o_rdata, rd, lo, d;
  logic o_irq, o_act, o_ev;
  logic [15:0] cnt = 0, ev_at = 0;
  int errors = 0, samples_checked = 0, ev_n = 0, cyc = 0, n0, r;
  int seed = 32'h5c81;

  always #25 i_clk = ~i_clk;

  periodic_tick_unit i_dut (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_bus(bus), .i_tick_source_clock(src), .i_power(pwr),
    .o_rdata(o_rdata), .o_irq(o_irq), .o_chain_active(o_act),
    .o_tick_event(o_ev));

  //////////////////////////////////////////////////////////////////////////
  // reference chain: steps on sampled source rises, idle in dark stop
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    pwr_q <= pwr;
    src_d <= src;
    if (src_run && cyc[0])
      src <= ~src;
    if (bus.wr && bus.addr == `TICK_CTRL_ADDR && !pwr_q.wait_mode &&
        !pwr_q.stop_mode)
      on_m <= bus.wdata[`TICK_ON_BIT];
    if (!on_m)
      cnt <= 16'h0000;
    else if (src && !src_d && !(pwr_q.stop_mode && !pwr_q.osc_run_in_stop))
      cnt <= cnt + 16'h0001;
    if (o_ev === 1'b1) begin
      ev_n <= ev_n + 1;
      ev_at <= cnt;
    end
    // ceiling well above the roughly 52000 cycles the tests need
    if (cyc == 80000) begin
      errors = errors + 1;
      report_and_stop();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  function automatic int div(input int rate);
    case (rate)
      0: return 32768;
      1: return 8192;
      2: return 2048;
      3: return 128;
      4: return 64;
      5: return 32;
      6: return 16;
      default: return 8;
    endcase
  endfunction : div

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clk);
    bus.addr <= a;
    bus.wdata <= v;
    bus.wr <= 1'b1;
    @(posedge i_clk);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [7:0] a);
    @(posedge i_clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge i_clk);
    bus.rd <= 1'b0;
    #1 rd = o_rdata;
  endtask : rdc

  // bounded wait for the next event, then its source edge count
  task automatic wait_ev(input logic [15:0] exp);
    int k;
    k = ev_n;
    repeat (20000) if (ev_n == k) @(posedge i_clk);
    if (ev_n == k) begin
      errors++;
      $display("ERROR %0t: no event in time", $time);
    end
    #1 chk(ev_at, exp);
  endtask : wait_ev

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    rdc(`TICK_CTRL_ADDR);
    chk(16'(rd), 16'h0000);
    rdc(8'h05);
    chk(16'(rd), 16'h0000);
    $display("reset test done");
    for (r = 7; r > 0; r--) begin
      al = 1'($random(seed));
      d = {1'b0, r[2:0], 1'b0, al, 2'b00};
      // rate is only changed while the chain is off
      wr(`TICK_CTRL_ADDR, d);
      wr(`TICK_CTRL_ADDR, d | 8'h02);
      wait_ev(16'(div(r) / 2));
      chk(16'(o_irq), 16'(al));
      rdc(`TICK_CTRL_ADDR);
      chk(16'(rd), 16'(d | 8'h82));
      wr(`TICK_CTRL_ADDR, d | 8'h02);
      rdc(`TICK_CTRL_ADDR);
      chk(16'(rd[7]), 16'h0001);
      wr(`TICK_CTRL_ADDR, d | 8'h0a);
      #1 chk(16'(o_irq), 16'h0000);
      if (r > 1)
        wait_ev(16'(div(r) / 2 + div(r)));
      wr(`TICK_CTRL_ADDR, d);
    end
    wr(`TICK_CTRL_ADDR, 8'h00);
    $display("rate test done");
    wr(`TICK_CTRL_ADDR, 8'h70);
    wr(`TICK_CTRL_ADDR, 8'h76);
    @(posedge i_clk);
    pwr <= 3'b100;
    rdc(`TICK_CTRL_ADDR);
    chk(16'(rd), 16'h0000);
    wait_ev(16'h0004);
    chk(16'(o_act), 16'h0001);
    @(posedge i_clk);
    pwr <= 3'b011;
    wait_ev(16'h000c);
    @(posedge i_clk);
    pwr <= 3'b010;
    n0 = ev_n;
    repeat (200) @(posedge i_clk);
    chk(16'(ev_n - n0), 16'h0000);
    chk(16'(o_act), 16'h0000);
    pwr <= 3'b000;
    // keep the rate while turning off and clearing
    wr(`TICK_CTRL_ADDR, 8'h78);
    #1 chk(16'(o_irq), 16'h0000);
    $display("power test done");
    wr(`TICK_CTRL_ADDR, 8'h02);
    n0 = ev_n;
    repeat (20000) @(posedge i_clk);
    src_run <= 1'b0;
    repeat (4) @(posedge i_clk);
    rdc(`TICK_COUNT_LO_ADDR);
    lo = rd;
    rdc(`TICK_COUNT_HI_ADDR);
    chk({rd, lo}, cnt);
    chk(16'(ev_n - n0), 16'h0000);
    wr(`TICK_CTRL_ADDR, 8'h00);
    rdc(`TICK_COUNT_LO_ADDR);
    chk(16'(rd), 16'h0000);
    chk(16'(o_act), 16'h0000);
    @(posedge i_clk);
    pwr <= 3'b100;
    repeat (8) @(posedge i_clk);
    chk(16'(o_act), 16'h0000);
    $display("count test done");
    report_and_stop();
  end
endmodule : tb_periodic_tick_unit

`default_nettype wire
